// File: core/ras_pkg.sv
// Shared constants and types of the return address stack
package ras_pkg;

  localparam int PC_W   = 21;
  localparam int LVL_W  = 5;
  localparam int DEPTH  = 31;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IRQ_W  = 2;

  // Level pointer values
  localparam logic [LVL_W-1:0] LVL_EMPTY = 5'h00;
  localparam logic [LVL_W-1:0] LVL_ONE   = 5'h01;
  localparam logic [LVL_W-1:0] LVL_LAST  = 5'h1E;
  localparam logic [LVL_W-1:0] LVL_FULL  = 5'h1F;

  // Program counter values
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CFG_OFS      = 12'hFE0;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 12'hFE4;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS   = 12'hFE8;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS  = 12'hFEC;
  localparam logic [ADDR_W-1:0] TOP_U_OFS    = 12'hFF0;
  localparam logic [ADDR_W-1:0] TOP_H_OFS    = 12'hFF4;
  localparam logic [ADDR_W-1:0] TOP_L_OFS    = 12'hFF8;
  localparam logic [ADDR_W-1:0] LVL_OFS      = 12'hFFC;

  // Field positions
  localparam int FULL_BIT   = 7;
  localparam int UNF_BIT    = 6;
  localparam int OVR_EN_BIT = 0;
  localparam int IRQ_FULL   = 0;
  localparam int IRQ_UNF    = 1;
  localparam int TOP_U_LSB  = 16;
  localparam int TOP_U_W    = 5;
  localparam int TOP_H_LSB  = 8;
  localparam int TOP_L_LSB  = 0;
  localparam int BYTE_W     = 8;

  // Reset values
  localparam logic             OVR_EN_RST = 1'b1;
  localparam logic             FLAG_RST   = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 2'h0;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_CALL,
    OP_PUSH,
    OP_RET,
    OP_POP
  } ras_op_t;

endpackage

// File: core/ras_stack_mem.sv
// Flip-flop storage for stack levels 1 to 31
`timescale 1ns/1ns
`default_nettype none
module ras_stack_mem
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  // Write port
  input  wire logic             wr_en_in,
  input  wire logic [LVL_W-1:0] wr_idx_in,
  input  wire logic [PC_W-1:0]  wr_data_in,
  // Read port
  input  wire logic [LVL_W-1:0] rd_idx_in,
  output logic      [PC_W-1:0]  rd_data_out
);

  logic [PC_W-1:0] entry_reg  [1:DEPTH];
  logic [PC_W-1:0] entry_next [1:DEPTH];

  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++) begin : g_entry
      always_comb begin
        entry_next[g] = entry_reg[g];
        if (wr_en_in && (wr_idx_in == LVL_W'(g))) begin
          entry_next[g] = wr_data_in;
        end
      end
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          entry_reg[g] <= PC_ZERO;
        end else begin
          entry_reg[g] <= entry_next[g];
        end
      end
    end
  endgenerate

  // Level zero has no storage
  assign rd_data_out = (rd_idx_in == LVL_EMPTY) ? PC_ZERO
                                                : entry_reg[rd_idx_in];

endmodule
`default_nettype wire

// File: core/ras_return_stack.sv
// Return address stack with APB registers and interrupt
//
// Contract
// - Level pointer is five bits, holding levels 0 to 31.
// - Push increments then writes; pop reads then decrements.
// - Device reset clears the level pointer.
// - Software reads and writes the level pointer directly.
// - Thirty-first push without pops sets the sticky full flag.
// - Full flag stays until software clear or power-on reset.
// - Overflow reset enable defaults to set.
// - Enabled: 31st push stores PC+2, sets full, resets; level zero.
// - Disabled: level stays 31; later pushes neither write nor move.
// - Pop when empty returns zero, sets underflow, level stays zero.
// - Underflow flag stays until software clear or power-on reset.
// - Underflow return only redirects and sets underflow; no reset, no configuration change.
// - Explicit push stores current PC as new top entry.
// - Explicit pop discards top by decrementing the level.
// - Top entry reachable as upper, high and low byte registers.
// - Status layout: full bit 7, underflow bit 6, zero 5, level 4-0.
// - Flags read one when their event occurred, else zero.
`timescale 1ns/1ns
`default_nettype none
module ras_return_stack
  import ras_pkg::*;
(
  // Clock and power-on reset
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  // Device reset, same clock
  input  wire logic              dev_rst_in,
  // Core requests
  input  wire logic              call_in,
  input  wire logic              push_in,
  input  wire logic              ret_in,
  input  wire logic              pop_in,
  input  wire logic [PC_W-1:0]   pc_in,
  // Core answers
  output logic      [PC_W-1:0]   ret_pc_out,
  output logic                   ret_valid_out,
  output logic                   overflow_reset_out,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic      [DATA_W-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Interrupt
  output logic                   irq_out
);

  // Bus state
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              hit;
  logic              wr_ok;
  logic              lvl_wr;
  logic              cfg_wr;
  logic              en_wr;
  logic              clr_wr;
  logic              top_u_wr;
  logic              top_h_wr;
  logic              top_l_wr;

  // Stack state
  // five-bit level
  logic [LVL_W-1:0]  level_reg;
  logic [LVL_W-1:0]  level_next;
  logic              full_reg;
  logic              full_next;
  logic              unf_reg;
  logic              unf_next;
  logic              ovr_en_reg;
  logic              ovr_en_next;
  logic [PC_W-1:0]   ret_pc_reg;
  logic [PC_W-1:0]   ret_pc_next;
  logic              ret_valid_reg;
  logic              ret_valid_next;
  logic              ovr_rst_reg;
  logic              ovr_rst_next;
  logic [IRQ_W-1:0]  stat_reg;
  logic [IRQ_W-1:0]  stat_next;
  logic [IRQ_W-1:0]  en_reg;
  logic [IRQ_W-1:0]  en_next;
  logic              irq_reg;
  logic              irq_next;
  logic [IRQ_W-1:0]  ev;
  ras_op_t           op;
  logic              wr_en;
  logic [LVL_W-1:0]  wr_idx;
  logic [PC_W-1:0]   wr_data;
  logic [PC_W-1:0]   top_rd;
  logic              clr_full;
  logic              clr_unf;

  ras_stack_mem u_mem (
    .ref_clk_in  (ref_clk_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (wr_en),
    .wr_idx_in   (wr_idx),
    .wr_data_in  (wr_data),
    .rd_idx_in   (level_reg),
    .rd_data_out (top_rd)
  );

  // APB decode, one wait state per access
  always_comb begin
    hit = 1'b1;
    prdata_next = '0;
    unique case (paddr_in)
      CFG_OFS: begin
        prdata_next[OVR_EN_BIT] = ovr_en_reg;
      end
      IRQ_STAT_OFS: begin
        prdata_next[IRQ_W-1:0] = stat_reg;
      end
      IRQ_EN_OFS: begin
        prdata_next[IRQ_W-1:0] = en_reg;
      end
      IRQ_CLR_OFS: begin
        prdata_next = '0;
      end
      TOP_U_OFS: begin
        prdata_next[TOP_U_W-1:0] = top_rd[PC_W-1:TOP_U_LSB];
      end
      TOP_H_OFS: begin
        prdata_next[BYTE_W-1:0] = top_rd[TOP_U_LSB-1:TOP_H_LSB];
      end
      TOP_L_OFS: begin
        prdata_next[BYTE_W-1:0] = top_rd[TOP_H_LSB-1:TOP_L_LSB];
      end
      LVL_OFS: begin
        prdata_next[FULL_BIT]    = full_reg;
        prdata_next[UNF_BIT]     = unf_reg;
        prdata_next[LVL_W-1:0]   = level_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    pready_next  = psel_in && penable_in && !pready_reg;
    pslverr_next = pready_next && !hit;
    if (!pready_next) begin
      prdata_next = '0;
    end
    wr_ok    = psel_in && penable_in && pready_reg && pwrite_in
               && pstrb_in[0];
    lvl_wr   = wr_ok && (paddr_in == LVL_OFS);
    cfg_wr   = wr_ok && (paddr_in == CFG_OFS);
    en_wr    = wr_ok && (paddr_in == IRQ_EN_OFS);
    clr_wr   = wr_ok && (paddr_in == IRQ_CLR_OFS);
    top_u_wr = wr_ok && (paddr_in == TOP_U_OFS);
    top_h_wr = wr_ok && (paddr_in == TOP_H_OFS);
    top_l_wr = wr_ok && (paddr_in == TOP_L_OFS);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Stack, flags, configuration and interrupt
  always_comb begin
    if (call_in) begin
      op = OP_CALL;
    end else if (push_in) begin
      op = OP_PUSH;
    end else if (ret_in) begin
      op = OP_RET;
    end else if (pop_in) begin
      op = OP_POP;
    end else begin
      op = OP_NONE;
    end
    level_next     = level_reg;
    full_next      = full_reg;
    unf_next       = unf_reg;
    ret_pc_next    = ret_pc_reg;
    ret_valid_next = 1'b0;
    ovr_rst_next   = 1'b0;
    ev             = '0;
    wr_en          = 1'b0;
    wr_idx         = level_reg;
    wr_data        = top_rd;
    ovr_en_next    = cfg_wr ? pwdata_in[OVR_EN_BIT] : ovr_en_reg;
    clr_full = lvl_wr && !pwdata_in[FULL_BIT];
    clr_unf  = lvl_wr && !pwdata_in[UNF_BIT];
    if (clr_full) begin
      full_next = 1'b0;
    end
    if (clr_unf) begin
      unf_next = 1'b0;
    end
    if (lvl_wr) begin
      level_next = pwdata_in[LVL_W-1:0];
    end
    // byte writes into the top entry
    if (level_reg != LVL_EMPTY) begin
      if (top_u_wr) begin
        wr_en = 1'b1;
        wr_data[PC_W-1:TOP_U_LSB] = pwdata_in[TOP_U_W-1:0];
      end else if (top_h_wr) begin
        wr_en = 1'b1;
        wr_data[TOP_U_LSB-1:TOP_H_LSB] = pwdata_in[BYTE_W-1:0];
      end else if (top_l_wr) begin
        wr_en = 1'b1;
        wr_data[TOP_H_LSB-1:TOP_L_LSB] = pwdata_in[BYTE_W-1:0];
      end
    end
    if (dev_rst_in) begin
      level_next = LVL_EMPTY;
      wr_en      = 1'b0;
    end else begin
      unique case (op)
        OP_NONE: begin
        end
        OP_CALL, OP_PUSH: begin
          if (level_reg == LVL_FULL) begin
            full_next     = 1'b1;
            ev[IRQ_FULL]  = 1'b1;
            wr_en         = 1'b0;
          end else begin
            wr_en   = 1'b1;
            wr_idx  = level_reg + LVL_ONE;
            wr_data = (op == OP_CALL) ? pc_in + PC_STEP : pc_in;
            level_next = level_reg + LVL_ONE;
            if (level_reg == LVL_LAST) begin
              full_next    = 1'b1;
              ev[IRQ_FULL] = 1'b1;
              if (ovr_en_reg) begin
                wr_data      = pc_in + PC_STEP;
                level_next   = LVL_EMPTY;
                ovr_rst_next = 1'b1;
              end
            end
          end
        end
        OP_RET, OP_POP: begin
          if (level_reg == LVL_EMPTY) begin
            unf_next    = 1'b1;
            ev[IRQ_UNF] = 1'b1;
            if (op == OP_RET) begin
              ret_valid_next = 1'b1;
              ret_pc_next    = PC_ZERO;
            end
          end else begin
            if (op == OP_RET) begin
              ret_valid_next = 1'b1;
              ret_pc_next    = top_rd;
            end
            level_next = level_reg - LVL_ONE;
            wr_en      = 1'b0;
          end
        end
      endcase
    end
    // Events win over clears
    stat_next = stat_reg;
    if (clr_wr) begin
      stat_next = stat_reg & ~pwdata_in[IRQ_W-1:0];
    end
    stat_next = stat_next | ev;
    en_next   = en_wr ? pwdata_in[IRQ_W-1:0] : en_reg;
    irq_next  = |(stat_next & en_next);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_reg     <= LVL_EMPTY;
      full_reg      <= FLAG_RST;
      unf_reg       <= FLAG_RST;
      ovr_en_reg    <= OVR_EN_RST;
      ret_pc_reg    <= PC_ZERO;
      ret_valid_reg <= 1'b0;
      ovr_rst_reg   <= 1'b0;
      stat_reg      <= IRQ_RST;
      en_reg        <= IRQ_RST;
      irq_reg       <= 1'b0;
    end else begin
      level_reg     <= level_next;
      full_reg      <= full_next;
      unf_reg       <= unf_next;
      ovr_en_reg    <= ovr_en_next;
      ret_pc_reg    <= ret_pc_next;
      ret_valid_reg <= ret_valid_next;
      ovr_rst_reg   <= ovr_rst_next;
      stat_reg      <= stat_next;
      en_reg        <= en_next;
      irq_reg       <= irq_next;
    end
  end

  assign prdata_out         = prdata_reg;
  assign pready_out         = pready_reg;
  assign pslverr_out        = pslverr_reg;
  assign ret_pc_out         = ret_pc_reg;
  assign ret_valid_out      = ret_valid_reg;
  assign overflow_reset_out = ovr_rst_reg;
  assign irq_out            = irq_reg;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  // push moves level up by one
  push_step_a: assert property (
    !dev_rst_in && (op inside {OP_CALL, OP_PUSH})
    && level_reg < LVL_LAST |=> level_reg == $past(level_reg) + LVL_ONE)
    else $error("push did not raise level by one");

  dev_reset_a: assert property (
    dev_rst_in |=> level_reg == LVL_EMPTY && full_reg == $past(full_reg)
    && unf_reg == $past(unf_reg))
    else $error("device reset wrong effect");

  full_set_a: assert property (
    !dev_rst_in && (op inside {OP_CALL, OP_PUSH})
    && level_reg == LVL_LAST |=> full_reg && stat_reg[IRQ_FULL])
    else $error("full flag not set");

  full_keep_a: assert property (
    full_reg && !clr_full |=> full_reg)
    else $error("full flag lost");

  ovr_reset_a: assert property (
    !dev_rst_in && ovr_en_reg && (op inside {OP_CALL, OP_PUSH})
    && level_reg == LVL_LAST
    |=> overflow_reset_out && level_reg == LVL_EMPTY
    ##1 !overflow_reset_out)
    else $error("overflow reset wrong");

  sat_hold_a: assert property (
    !dev_rst_in && !lvl_wr && (op inside {OP_CALL, OP_PUSH})
    && level_reg == LVL_FULL |=> level_reg == LVL_FULL
    && $stable(u_mem.entry_reg[DEPTH]))
    else $error("saturated push moved stack");

  unf_ret_a: assert property (
    !dev_rst_in && !lvl_wr && op == OP_RET && level_reg == LVL_EMPTY
    |=> ret_valid_out && ret_pc_out == PC_ZERO && unf_reg
    && level_reg == LVL_EMPTY)
    else $error("underflow return wrong");

  unf_keep_a: assert property (
    unf_reg && !clr_unf |=> unf_reg [*1] ##0 unf_reg)
    else $error("underflow flag lost");

  unf_norst_a: assert property (
    !dev_rst_in && (op inside {OP_RET, OP_POP})
    && level_reg == LVL_EMPTY |=> !overflow_reset_out
    && ovr_en_reg == $past(ovr_en_reg))
    else $error("underflow disturbed registers");

  pop_step_a: assert property (
    !dev_rst_in && !lvl_wr && (op inside {OP_RET, OP_POP})
    && level_reg != LVL_EMPTY |=> level_reg == $past(level_reg) - LVL_ONE)
    else $error("pop did not lower level");

  top_zero_a: assert property (
    level_reg == LVL_EMPTY |-> top_rd == PC_ZERO)
    else $error("level zero top not zero");

endmodule
`default_nettype wire

// File: verification/ras_core_model.sv
// Behavioural model of the core issuing stack requests
`timescale 1ns/1ns
`default_nettype none
module ras_core_model
  import ras_pkg::*;
(
  // Clock
  input  wire logic            ref_clk_in,
  // Requests
  output logic                 call_out,
  output logic                 push_out,
  output logic                 ret_out,
  output logic                 pop_out,
  output logic      [PC_W-1:0] pc_out,
  // Answers
  input  wire logic [PC_W-1:0] ret_pc_in,
  input  wire logic            ret_valid_in,
  input  wire logic            overflow_reset_in
);
  logic [PC_W-1:0] last_ret;
  int              ovr_count;
  int              miss_count;

  initial begin
    {call_out, push_out, ret_out, pop_out} = 4'h0;
    pc_out = PC_ZERO;
    last_ret = PC_ZERO;
    ovr_count = 0;
    miss_count = 0;
  end

  always @(negedge ref_clk_in) begin
    if (overflow_reset_in === 1'b1) begin
      ovr_count <= ovr_count + 1;
    end
  end

  // One request pulse; a return waits for its answer
  task automatic do_op(input ras_op_t op, input logic [PC_W-1:0] pc);
    int n;
    @(posedge ref_clk_in);
    pc_out <= pc;
    call_out <= (op == OP_CALL);
    push_out <= (op == OP_PUSH);
    ret_out <= (op == OP_RET);
    pop_out <= (op == OP_POP);
    @(posedge ref_clk_in);
    {call_out, push_out, ret_out, pop_out} <= 4'h0;
    pc_out <= ~pc;
    if (op == OP_RET) begin
      n = 0;
      @(negedge ref_clk_in);
      while (ret_valid_in !== 1'b1 && n < 4) begin
        @(negedge ref_clk_in);
        n++;
      end
      if (ret_valid_in === 1'b1) begin
        last_ret = ret_pc_in;
      end else begin
        miss_count++;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verification/ras_return_stack_tb.sv
// Self-checking bench of the return address stack
`timescale 1ns/1ns
`default_nettype none
module ras_return_stack_tb
  import ras_pkg::*;
;
  logic              ref_clk_in;
  logic              nrst_in;
  logic              dev_rst;
  logic              call;
  logic              push;
  logic              ret;
  logic              pop;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   ret_pc;
  logic              ret_valid;
  logic              ovr_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [DATA_W-1:0] q;
  logic              e;
  int                bad_count;
  int                comparisons;

  ras_return_stack i_dut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .dev_rst_in(dev_rst),
    .call_in(call), .push_in(push), .ret_in(ret), .pop_in(pop),
    .pc_in(pc), .ret_pc_out(ret_pc), .ret_valid_out(ret_valid),
    .overflow_reset_out(ovr_rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq)
  );

  ras_core_model i_core (
    .ref_clk_in(ref_clk_in), .call_out(call), .push_out(push),
    .ret_out(ret), .pop_out(pop), .pc_out(pc), .ret_pc_in(ret_pc),
    .ret_valid_in(ret_valid), .overflow_reset_in(ovr_rst)
  );

  always #50 ref_clk_in = ~ref_clk_in;

  task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    n = 0;
    // Request stands until pready is seen at a rising edge
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input string nm, input logic [ADDR_W-1:0] a,
                    input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, q, {24'h0, exp});
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge ref_clk_in);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic dev_reset;
    @(posedge ref_clk_in);
    dev_rst <= 1'b1;
    @(posedge ref_clk_in);
    dev_rst <= 1'b0;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    results;
  end

  initial begin
    ref_clk_in = 1'b0;
    nrst_in = 1'b0;
    dev_rst = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd("level", LVL_OFS, 8'h00);
    rd("config", CFG_OFS, 8'h01);
    apb(1'b0, 12'h000, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    i_core.do_op(OP_CALL, 21'h000100);
    i_core.do_op(OP_PUSH, 21'h012345);
    rd("level", LVL_OFS, 8'h02);
    rd("top upper", TOP_U_OFS, 8'h01);
    rd("top high", TOP_H_OFS, 8'h23);
    rd("top low", TOP_L_OFS, 8'h45);
    i_core.do_op(OP_POP, PC_ZERO);
    rd("level", LVL_OFS, 8'h01);
    rd("top low", TOP_L_OFS, 8'h02);
    i_core.do_op(OP_RET, PC_ZERO);
    check("return", {11'h0, i_core.last_ret}, 32'h102);
    i_core.do_op(OP_RET, PC_ZERO);
    check("underflow ret", {11'h0, i_core.last_ret}, 32'h0);
    rd("level", LVL_OFS, 8'h40);
    rd("top low", TOP_L_OFS, 8'h00);
    rd("config", CFG_OFS, 8'h01);
    wr(LVL_OFS, 8'h45);
    rd("level", LVL_OFS, 8'h45);
    dev_reset;
    rd("level", LVL_OFS, 8'h40);
    wr(LVL_OFS, 8'h00);
    rd("level", LVL_OFS, 8'h00);
    i_core.do_op(OP_CALL, PC_ZERO);
    wr(TOP_U_OFS, 8'h1A);
    wr(TOP_H_OFS, 8'hBC);
    wr(TOP_L_OFS, 8'hDE);
    i_core.do_op(OP_RET, PC_ZERO);
    check("top write", {11'h0, i_core.last_ret}, 32'h1ABCDE);
    wr(LVL_OFS, 8'h1E);
    i_core.do_op(OP_PUSH, 21'h000400);
    rd("level", LVL_OFS, 8'h80);
    check("ovr pulses", i_core.ovr_count, 32'h1);
    wr(LVL_OFS, 8'h9F);
    rd("top low", TOP_L_OFS, 8'h02);
    rd("top high", TOP_H_OFS, 8'h04);
    dev_reset;
    rd("level", LVL_OFS, 8'h80);
    wr(CFG_OFS, 8'h00);
    rd("config", CFG_OFS, 8'h00);
    wr(LVL_OFS, 8'h00);
    for (int i = 1; i <= 31; i++) begin
      i_core.do_op(OP_PUSH, PC_W'(i));
    end
    rd("level", LVL_OFS, 8'h9F);
    i_core.do_op(OP_PUSH, 21'h000055);
    rd("level", LVL_OFS, 8'h9F);
    rd("top low", TOP_L_OFS, 8'h1F);
    check("ovr pulses", i_core.ovr_count, 32'h1);
    for (int i = 31; i >= 1; i--) begin
      i_core.do_op(OP_RET, PC_ZERO);
      check("return", {11'h0, i_core.last_ret}, 32'(i));
    end
    rd("level", LVL_OFS, 8'h80);
    rd("irq status", IRQ_STAT_OFS, 8'h03);
    irq_chk(1'b0);
    wr(IRQ_EN_OFS, 8'h03);
    irq_chk(1'b1);
    wr(IRQ_CLR_OFS, 8'h03);
    irq_chk(1'b0);
    rd("irq clear", IRQ_CLR_OFS, 8'h00);
    rd("irq status", IRQ_STAT_OFS, 8'h00);
    i_core.do_op(OP_RET, PC_ZERO);
    irq_chk(1'b1);
    rd("irq status", IRQ_STAT_OFS, 8'h02);
    wr(IRQ_EN_OFS, 8'h01);
    irq_chk(1'b0);
    wr(LVL_OFS, 8'h80);
    i_core.do_op(OP_POP, PC_ZERO);
    rd("level", LVL_OFS, 8'hC0);
    check("missed returns", i_core.miss_count, 32'h0);
    results;
  end
endmodule
`default_nettype wire
